// ---- include/epmc_defs.vh ----
`ifndef EPMC_DEFS_VH
`define EPMC_DEFS_VH

// Configured speed encodings
`define EPMC_SPD_DISABLED   4'h0
`define EPMC_SPD_AUTO       4'h1
`define EPMC_SPD_10H        4'h2
`define EPMC_SPD_10F        4'h3
`define EPMC_SPD_100H       4'h4
`define EPMC_SPD_100F       4'h5
`define EPMC_SPD_1GF        4'h6
`define EPMC_SPD_2G5F       4'h7
`define EPMC_SPD_10GF       4'h8

// Current link speed encodings
`define EPMC_LS_NONE        3'h0
`define EPMC_LS_10M         3'h1
`define EPMC_LS_100M        3'h2
`define EPMC_LS_1G          3'h3
`define EPMC_LS_2G5         3'h4
`define EPMC_LS_5G          3'h5
`define EPMC_LS_10G         3'h6

// Advertise bit positions: speed mask 10M..10G at bits 0..5
`define EPMC_ADV_SPD_ALL    6'h3f
`define EPMC_ADV_DPX_ALL    2'h3
`define EPMC_DPX_FDX_BIT    0
`define EPMC_DPX_HDX_BIT    1

`define EPMC_PFC_PRIO_ALL   8'hff
`define EPMC_MFS_MIN        14'h05ee
`define EPMC_MFS_MAX        14'h2748
`define EPMC_MFS_RST        14'h2800
`define EPMC_COLL_LIMIT     5'h10
`define EPMC_LEN_TYPE_MAX   16'h05ff

`endif

// ---- hdl/epmc_port.v ----
// Function
// - Disabled speed setting stops all port operation.
// - Automatic mode negotiates and picks highest common speed.
// - Forced modes 10/100 half or full, 1G/2.5G/10G full only.
// - Negotiation advertises only configured duplexes; default advertises all.
// - Negotiation advertises only selected speeds; default advertises all.
// - Flow control advertised in auto mode, applied directly in forced full-duplex modes only.
// - Report pause obey and pause transmit following last negotiation.
// - Priority flow control pauses only the configured priorities.
// - PFC not negotiated; PFC disables pause advertisement and tx_pause, auto-mode fc_tx_pause keeps its last negotiated value.
// - Discard mode drops frame after 16 collisions.
// - Restart mode restarts backoff after 16 collisions instead.
// - Length/type 1535 or less is length, larger is type.
// - Length check on drops payload under 1536 with mismatched length.
// - Length check off never drops for length mismatch.
// - Length mismatch drops increment no drop counter.
// - Report link state, current speed and warning indication.
// - Forced 10 or 100 megabit modes turn crossover detection off.
`timescale 1ns/1ns
`default_nettype none
`include "epmc_defs.vh"

module epmc_port #(
  parameter CNT_W = 32
) (
  input  wire              clk,
  input  wire              rst_b,
  input  wire              ce,
  // Configuration
  input  wire [3:0]        cfg_speed,
  input  wire [1:0]        cfg_adv_dpx,
  input  wire [5:0]        cfg_adv_spd,
  input  wire              cfg_fc_en,
  input  wire              cfg_pfc_en,
  input  wire [7:0]        cfg_pfc_prio,
  input  wire [13:0]       cfg_max_frame,
  input  wire              cfg_coll_restart,
  input  wire              cfg_len_check,
  // Negotiation engine (pins, synchronised here)
  input  wire              an_done,
  input  wire [5:0]        an_lp_spd,
  input  wire [1:0]        an_lp_dpx,
  input  wire              an_lp_pause,
  input  wire              phy_link,
  // Transmit events from the MAC core
  input  wire              tx_coll,
  input  wire              tx_ok,
  // Receive frame end
  input  wire              rx_end,
  input  wire [15:0]       rx_len_type,
  input  wire [13:0]       rx_payload_len,
  input  wire              rx_err_drop,
  // Pause requests from the partner, per priority and ordinary
  input  wire [7:0]        rx_pfc_req,
  input  wire              rx_pause_req,
  // Outputs
  output reg               port_en,
  output reg  [5:0]        adv_spd,
  output reg  [1:0]        adv_dpx,
  output reg               adv_pause,
  output reg               fc_rx_obey,
  output reg               fc_tx_pause,
  output reg  [7:0]        pfc_pause,
  output reg               tx_pause,
  output reg  [13:0]       max_frame,
  output reg               tx_discard,
  output reg               tx_backoff_restart,
  output reg  [4:0]        coll_cnt,
  output reg               rx_is_type,
  output reg               rx_len_drop,
  output reg  [CNT_W-1:0]  rx_drop_cnt,
  output reg               link_up,
  output reg  [2:0]        link_speed,
  output reg               link_fdx,
  output reg               warning,
  output reg               mdix_auto_en
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

  function forced_mode;
    input [3:0] s;
    begin
      forced_mode = (s >= `EPMC_SPD_10H) && (s <= `EPMC_SPD_10GF);
    end
  endfunction

  function [2:0] forced_speed;
    input [3:0] s;
    begin
      case (s)
        `EPMC_SPD_10H, `EPMC_SPD_10F:   forced_speed = `EPMC_LS_10M;
        `EPMC_SPD_100H, `EPMC_SPD_100F: forced_speed = `EPMC_LS_100M;
        `EPMC_SPD_1GF:                  forced_speed = `EPMC_LS_1G;
        `EPMC_SPD_2G5F:                 forced_speed = `EPMC_LS_2G5;
        `EPMC_SPD_10GF:                 forced_speed = `EPMC_LS_10G;
        default:                        forced_speed = `EPMC_LS_NONE;
      endcase
    end
  endfunction

  // Highest set bit of a speed mask, mapped to link speed code
  function [2:0] top_speed;
    input [5:0] m;
    integer i;
    begin
      top_speed = `EPMC_LS_NONE;
      for (i = 0; i < 6; i = i + 1)
        if (m[i])
          top_speed = i[2:0] + 3'h1;
    end
  endfunction

////////////////////////////////////////////////////////////////////////////////
// Synchronisers for pin inputs

  reg  [10:0] sync1_reg;
  reg  [10:0] sync2_reg;
  wire [10:0] pin_raw = {phy_link, an_lp_pause, an_lp_dpx, an_lp_spd, an_done};

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      sync1_reg <= 11'h000;
      sync2_reg <= 11'h000;
    end
    else if (ce)
    begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  wire       s_link    = sync2_reg[10];
  wire       s_lp_paus = sync2_reg[9];
  wire [1:0] s_lp_dpx  = sync2_reg[8:7];
  wire [5:0] s_lp_spd  = sync2_reg[6:1];
  wire       s_an_done = sync2_reg[0];

////////////////////////////////////////////////////////////////////////////////
// Configuration decode

  wire is_disabled = (cfg_speed == `EPMC_SPD_DISABLED);
  wire is_auto     = (cfg_speed == `EPMC_SPD_AUTO);
  wire is_forced   = forced_mode(cfg_speed);
  wire forced_hdx  = (cfg_speed == `EPMC_SPD_10H) || (cfg_speed == `EPMC_SPD_100H);
  // PFC wins a conflicting request; ordinary pause is then held off
  wire fc_allowed  = cfg_fc_en && !cfg_pfc_en;
  // Keep frame size inside its legal window rather than rejecting
  wire [13:0] mfs_clamped = (cfg_max_frame < `EPMC_MFS_MIN) ? `EPMC_MFS_MIN :
                            (cfg_max_frame > `EPMC_MFS_MAX) ? `EPMC_MFS_MAX :
                            cfg_max_frame;
  wire [5:0] common_spd = adv_spd & s_lp_spd;
  wire [1:0] common_dpx = adv_dpx & s_lp_dpx;
  reg        an_done_d_reg;
  wire       an_rise    = s_an_done && !an_done_d_reg;

////////////////////////////////////////////////////////////////////////////////
// Link, advertisement and flow control state

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      port_en       <= 1'b0;
      adv_spd       <= `EPMC_ADV_SPD_ALL;
      adv_dpx       <= `EPMC_ADV_DPX_ALL;
      adv_pause     <= 1'b0;
      fc_rx_obey    <= 1'b0;
      fc_tx_pause   <= 1'b0;
      max_frame     <= `EPMC_MFS_MAX;
      link_up       <= 1'b0;
      link_speed    <= `EPMC_LS_NONE;
      link_fdx      <= 1'b0;
      warning       <= 1'b0;
      mdix_auto_en  <= 1'b1;
      an_done_d_reg <= 1'b0;
    end
    else if (ce)
    begin
      an_done_d_reg <= s_an_done;
      port_en       <= !is_disabled;
      max_frame     <= mfs_clamped;
      adv_spd       <= cfg_adv_spd;
      adv_dpx       <= cfg_adv_dpx;
      adv_pause     <= is_auto && fc_allowed;
      mdix_auto_en  <= !(is_forced && (forced_speed(cfg_speed) <= `EPMC_LS_100M));
      warning       <= (cfg_max_frame != mfs_clamped) || (cfg_fc_en && cfg_pfc_en)
                       || (is_auto && s_an_done && common_spd == 6'h00);
      if (is_disabled || !s_link)
      begin
        link_up    <= 1'b0;
        link_speed <= `EPMC_LS_NONE;
        link_fdx   <= 1'b0;
        if (is_disabled)
        begin
          fc_rx_obey  <= 1'b0;
          fc_tx_pause <= 1'b0;
        end
      end
      else if (is_forced)
      begin
        link_up     <= 1'b1;
        link_speed  <= forced_speed(cfg_speed);
        link_fdx    <= !forced_hdx;
        fc_rx_obey  <= fc_allowed && !forced_hdx;
        fc_tx_pause <= fc_allowed && !forced_hdx;
      end
      else if (s_an_done)
      begin
        link_up    <= (common_spd != 6'h00);
        link_speed <= top_speed(common_spd);
        link_fdx   <= common_dpx[`EPMC_DPX_FDX_BIT];
        if (an_rise)
        begin
          // Pause result frozen until the next negotiation completes
          fc_rx_obey  <= adv_pause && s_lp_paus && common_dpx[`EPMC_DPX_FDX_BIT];
          fc_tx_pause <= adv_pause && s_lp_paus && common_dpx[`EPMC_DPX_FDX_BIT];
        end
      end
      else
        link_up <= 1'b0;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Pause application

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      pfc_pause <= 8'h00;
      tx_pause  <= 1'b0;
    end
    else if (ce)
    begin
      pfc_pause <= (port_en && cfg_pfc_en) ? (rx_pfc_req & cfg_pfc_prio) : 8'h00;
      tx_pause  <= port_en && fc_rx_obey && !cfg_pfc_en && rx_pause_req;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Excessive collision handling

  wire coll_hit = port_en && tx_coll && (coll_cnt == `EPMC_COLL_LIMIT - 5'h01);

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      coll_cnt           <= 5'h00;
      tx_discard         <= 1'b0;
      tx_backoff_restart <= 1'b0;
    end
    else if (ce)
    begin
      tx_discard         <= coll_hit && !cfg_coll_restart;
      tx_backoff_restart <= coll_hit && cfg_coll_restart;
      if (!port_en || tx_ok || coll_hit)
        coll_cnt <= 5'h00;
      else if (tx_coll)
        coll_cnt <= coll_cnt + 5'h01;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Receive length check

  wire len_is_len = (rx_len_type <= `EPMC_LEN_TYPE_MAX);
  wire len_bad    = cfg_len_check && len_is_len
                    && (rx_payload_len <= `EPMC_LEN_TYPE_MAX)
                    && (rx_len_type != {2'b00, rx_payload_len});

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      rx_is_type  <= 1'b0;
      rx_len_drop <= 1'b0;
      rx_drop_cnt <= {CNT_W{1'b0}};
    end
    else if (ce)
    begin
      rx_len_drop <= port_en && rx_end && len_bad;
      if (port_en && rx_end)
        rx_is_type <= !len_is_len;
      // Length drops are silent; only other drops count
      if (port_en && rx_end && rx_err_drop && !len_bad)
        rx_drop_cnt <= rx_drop_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

// ---- bench/epmc_port_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module epmc_port_checker #(
  parameter CNT_W = 32
) (
  input wire             clk,
  input wire             rst_b,
  input wire             ce,
  input wire [3:0]       cfg_speed,
  input wire             cfg_pfc_en,
  input wire             cfg_coll_restart,
  input wire             cfg_len_check,
  input wire             tx_coll,
  input wire             rx_end,
  input wire [15:0]      rx_len_type,
  input wire [13:0]      rx_payload_len,
  input wire             port_en,
  input wire             tx_pause,
  input wire [13:0]      max_frame,
  input wire             tx_discard,
  input wire             tx_backoff_restart,
  input wire [4:0]       coll_cnt,
  input wire             rx_is_type,
  input wire             rx_len_drop,
  input wire [CNT_W-1:0] rx_drop_cnt,
  input wire             mdix_auto_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_disabled_port_off: assert property (ce && cfg_speed == 4'h0 |=> !port_en)
    else $error("port stays enabled while disabled");
  a_forced_mdix_off: assert property (ce && cfg_speed >= 4'h2 && cfg_speed <= 4'h5
    |=> !mdix_auto_en) else $error("crossover detection on in forced mode");
  a_coll_discard: assert property (ce && port_en && tx_coll && coll_cnt == 5'h0f
    && !cfg_coll_restart |=> tx_discard && !tx_backoff_restart && coll_cnt == 5'h00)
    else $error("no discard after sixteen collisions");
  a_coll_restart: assert property (ce && port_en && tx_coll && coll_cnt == 5'h0f
    && cfg_coll_restart |=> tx_backoff_restart && !tx_discard && coll_cnt == 5'h00)
    else $error("no backoff restart after sixteen collisions");
  a_len_mismatch_drop: assert property (ce && port_en && rx_end && cfg_len_check
    && rx_len_type <= 16'h05ff && rx_payload_len <= 14'h05ff
    && rx_len_type != {2'b00, rx_payload_len} |=> rx_len_drop) else $error("mismatch kept");
  a_no_check_keep: assert property (ce && rx_end && !cfg_len_check |=> !rx_len_drop)
    else $error("length drop with check off");
  a_len_drop_uncounted: assert property (rx_len_drop |->
    rx_drop_cnt == $past(rx_drop_cnt)) else $error("length drop counted");
  a_type_field: assert property (ce && port_en && rx_end |=>
    rx_is_type == ($past(rx_len_type) > 16'h05ff)) else $error("type decision wrong");
  a_pfc_excl_pause: assert property ((ce && cfg_pfc_en)[*2] |=> !tx_pause)
    else $error("pause active beside priority control");
  a_frame_size_range: assert property (max_frame >= 14'h05ee && max_frame <= 14'h2748)
    else $error("frame size limit out of range");
endmodule
bind epmc_port epmc_port_checker #(.CNT_W(CNT_W)) u_chk (
  .clk, .rst_b, .ce, .cfg_speed, .cfg_pfc_en, .cfg_coll_restart, .cfg_len_check,
  .tx_coll, .rx_end, .rx_len_type, .rx_payload_len, .port_en, .tx_pause, .max_frame,
  .tx_discard, .tx_backoff_restart, .coll_cnt, .rx_is_type, .rx_len_drop, .rx_drop_cnt,
  .mdix_auto_en
);
`default_nettype wire

// ---- bench/epmc_lp_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module epmc_lp_model (
  input wire        clk,
  input wire        go,
  input wire [5:0]  spd,
  input wire [1:0]  dpx,
  input wire        pause,
  output reg        an_done = 1'b0,
  output reg [5:0]  an_lp_spd = 6'h00,
  output reg [1:0]  an_lp_dpx = 2'h0,
  output reg        an_lp_pause = 1'b0,
  output reg        phy_link = 1'b0
);
  reg [1:0] cnt_reg = 2'h0;
  // Done drops on each new start so the port sees a fresh rising edge
  always @(posedge clk)
  begin
    if (go)
    begin
      {an_done, an_lp_spd, an_lp_dpx, an_lp_pause, phy_link} <= {1'b0, spd, dpx, pause, 1'b1};
      cnt_reg <= 2'h3;
    end
    else if (cnt_reg != 2'h0)
    begin
      cnt_reg <= cnt_reg - 2'h1;
      an_done <= (cnt_reg == 2'h1);
    end
  end
endmodule
`default_nettype wire

// ---- bench/epmc_port_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module epmc_port_tb;
  logic clk = 0, rst_b = 0, go = 0, lp_pause = 1, cfg_fc_en = 0, cfg_pfc_en = 0;
  logic cfg_coll_restart = 0, cfg_len_check = 1, tx_coll = 0, tx_ok = 0, rx_end = 0;
  logic rx_err_drop = 0, rx_pause_req = 0, ce = 1;
  logic [3:0] cfg_speed = 4'h0;
  logic [1:0] cfg_adv_dpx = 2'h3, lp_dpx = 2'h3;
  logic [5:0] cfg_adv_spd = 6'h3f, lp_spd = 6'h3f;
  logic [7:0] cfg_pfc_prio = 8'h8f, rx_pfc_req = 8'h00, pfc_pause;
  logic [13:0] cfg_max_frame = 14'h2748, rx_payload_len = 14'h0000, max_frame;
  logic [15:0] rx_len_type = 16'h0000;
  wire an_done, an_lp_pause, phy_link, port_en, adv_pause, fc_rx_obey, fc_tx_pause, tx_pause;
  wire tx_discard, tx_backoff_restart, rx_is_type, rx_len_drop, link_up, link_fdx, warning;
  wire mdix_auto_en;
  wire [5:0] an_lp_spd, adv_spd;
  wire [1:0] an_lp_dpx, adv_dpx;
  wire [4:0] coll_cnt;
  wire [2:0] link_speed;
  wire [31:0] rx_drop_cnt;
  integer num_errors = 0, samples_checked = 0, i, e_cnt = 0;
  always #50 clk = ~clk;
  epmc_lp_model u_lp (.clk, .go, .spd(lp_spd), .dpx(lp_dpx), .pause(lp_pause), .an_done,
    .an_lp_spd, .an_lp_dpx, .an_lp_pause, .phy_link);
  epmc_port #(.CNT_W(32)) dut (.clk, .rst_b, .ce, .cfg_speed, .cfg_adv_dpx,
    .cfg_adv_spd, .cfg_fc_en, .cfg_pfc_en, .cfg_pfc_prio, .cfg_max_frame, .cfg_coll_restart,
    .cfg_len_check, .an_done, .an_lp_spd, .an_lp_dpx, .an_lp_pause, .phy_link, .tx_coll,
    .tx_ok, .rx_end, .rx_len_type, .rx_payload_len, .rx_err_drop, .rx_pfc_req, .rx_pause_req,
    .port_en, .adv_spd, .adv_dpx, .adv_pause, .fc_rx_obey, .fc_tx_pause, .pfc_pause, .tx_pause,
    .max_frame, .tx_discard, .tx_backoff_restart, .coll_cnt, .rx_is_type, .rx_len_drop,
    .rx_drop_cnt, .link_up, .link_speed, .link_fdx, .warning, .mdix_auto_en);
  ////////////////////////////////////////////////////////////////////////////////
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #10;
    end
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        num_errors = num_errors + 1;
        $display("Error %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // A new negotiation; the sync stages in the port need the long wait
  task neg(input logic [5:0] s, input logic p);
    begin
      {lp_spd, lp_pause, go} = {s, p, 1'b1};
      cyc(1);
      go = 0;
      cyc(10);
    end
  endtask
  task coll(input integer n);
    repeat (n)
    begin
      tx_coll = 1;
      cyc(1);
      tx_coll = 0;
      cyc(1);
    end
  endtask
  task rx(input logic [15:0] lt, input logic [13:0] pl, input logic ck, input logic ed,
          input logic e_drop, input logic e_type);
    begin
      {rx_len_type, rx_payload_len, cfg_len_check, rx_err_drop, rx_end} = {lt, pl, ck, ed, 1'b1};
      cyc(1);
      rx_end = 0;
      e_cnt = e_cnt + (ed & !e_drop);
      chk("rx_len_drop", rx_len_drop, e_drop);
      chk("rx_is_type", rx_is_type, e_type);
      chk("rx_drop_cnt", rx_drop_cnt, e_cnt);
      cyc(1);
    end
  endtask
  initial
  begin
    #1000000;
    num_errors = num_errors + 1;
    tally_and_finish;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(12);
    rst_b = 1;
    chk("adv_spd", adv_spd, 6'h3f);
    chk("adv_dpx", adv_dpx, 2'h3);
    neg(6'h3f, 1);
    for (i = 2; i <= 8; i = i + 1)
    begin
      cfg_speed = i;
      cyc(4);
      chk("port_en", port_en, 1);
      chk("link_speed", link_speed, i < 6 ? i / 2 : (i == 8 ? 6 : i - 3));
      chk("link_fdx", link_fdx, i[0] | (i > 5));
      chk("mdix_auto_en", mdix_auto_en, i > 5);
      chk("link_up", link_up, 1);
    end
    cfg_speed = 0;
    coll(3);
    chk("coll_cnt", coll_cnt, 0);
    {cfg_speed, cfg_adv_spd, cfg_adv_dpx, cfg_fc_en, rx_pause_req} = 14'h0477;
    cyc(2);
    chk("adv_spd", adv_spd, 6'h07);
    chk("adv_dpx", adv_dpx, 2'h1);
    chk("adv_pause", adv_pause, 1);
    neg(6'h06, 1);
    chk("link_speed", link_speed, 3);
    chk("link_fdx", link_fdx, 1);
    chk("fc_tx_pause", fc_tx_pause, 1);
    chk("tx_pause", tx_pause, 1);
    neg(6'h06, 0);
    chk("fc_rx_obey", fc_rx_obey, 0);
    neg(6'h06, 1);
    {cfg_pfc_en, rx_pfc_req} = 9'h1ff;
    cyc(3);
    chk("tx_pause", tx_pause, 0);
    chk("warning", warning, 1);
    chk("pfc_pause", pfc_pause, 8'h8f);
    {cfg_pfc_en, rx_pfc_req, rx_pause_req} = 10'h000;
    neg(6'h38, 1);
    chk("link_up", link_up, 0);
    cfg_max_frame = 14'h05ed;
    cyc(2);
    chk("max_frame", max_frame, 14'h05ee);
    cfg_max_frame = 14'h2749;
    cyc(2);
    chk("max_frame", max_frame, 14'h2748);
    cfg_speed = 2;
    cyc(4);
    for (i = 0; i < 2; i = i + 1)
    begin
      cfg_coll_restart = i;
      coll(15);
      chk("coll_cnt", coll_cnt, 15);
      tx_coll = 1;
      cyc(1);
      tx_coll = 0;
      chk("tx_discard", tx_discard, !i);
      chk("tx_backoff_restart", tx_backoff_restart, i);
      chk("coll_cnt", coll_cnt, 0);
      cyc(1);
    end
    coll(3);
    // Clock enable low must freeze the count even with a success pending
    {ce, tx_ok} = 2'b01;
    cyc(2);
    chk("coll_cnt", coll_cnt, 3);
    ce = 1;
    cyc(1);
    tx_ok = 0;
    chk("coll_cnt", coll_cnt, 0);
    rx(16'h0064, 14'h0063, 1, 0, 1, 0);
    rx(16'h0064, 14'h0064, 1, 0, 0, 0);
    rx(16'h05ff, 14'h05fe, 1, 0, 1, 0);
    rx(16'h0600, 14'h000a, 1, 0, 0, 1);
    rx(16'h0064, 14'h0063, 0, 0, 0, 0);
    rx(16'h0064, 14'h0600, 1, 0, 0, 0);
    rx(16'h0064, 14'h0063, 1, 1, 1, 0);
    rx(16'h0064, 14'h0064, 1, 1, 0, 0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
